// ### shared/cirq_pkg.sv
`default_nettype none
package cirq_pkg;
	// register byte addresses on the apb side
	localparam logic [11:0] OFS_GIT    = 12'h000;
	localparam logic [11:0] OFS_GIE    = 12'h004;
	localparam logic [11:0] OFS_EN_LO  = 12'h008;
	localparam logic [11:0] OFS_EN_HI  = 12'h00c;
	localparam logic [11:0] OFS_IE_LO  = 12'h010;
	localparam logic [11:0] OFS_IE_HI  = 12'h014;
	localparam logic [11:0] OFS_SIT_LO = 12'h018;
	localparam logic [11:0] OFS_SIT_HI = 12'h01c;
	localparam logic [11:0] OFS_BT1    = 12'h020;
	localparam logic [11:0] OFS_BT2    = 12'h024;
	localparam logic [11:0] OFS_BUFSEL = 12'h028;
	// general interrupt flag positions
	localparam int GIT_IND   = 7;
	localparam int GIT_BOFF  = 6;
	localparam int GIT_OVR   = 5;
	localparam int GIT_FB    = 4;
	localparam int GIT_STUFF = 3;
	localparam int GIT_CRC   = 2;
	localparam int GIT_FORM  = 1;
	localparam int GIT_ACK   = 0;
	// general enable positions
	localparam int GIE_MASTER = 7;
	localparam int GIE_BOFF   = 6;
	localparam int GIE_RX     = 5;
	localparam int GIE_TX     = 4;
	localparam int GIE_OERR   = 3;
	localparam int GIE_FB     = 2;
	localparam int GIE_GERR   = 1;
	localparam int GIE_OVR    = 0;
	// bit timing field positions and reset values
	localparam int PRESC_LSB = 1;
	localparam int JUMP_LSB  = 5;
	localparam int PROP_LSB  = 1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// quantum segments of one bit
	typedef enum logic [1:0] {seg_sync, seg_prop, seg_ph1, seg_ph2} cirq_seg_type;
endpackage
`default_nettype wire

// ### shared/cirq_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cirq_core_if #(parameter int NOBJ = 6);
	logic [5:0]      prescale;  // quantum prescaler
	logic [1:0]      jump_w;    // resync jump width
	logic [2:0]      prop_seg;  // propagation segment
	logic            rx_level;  // synchronised bus level
	logic            bus_idle;  // hard sync permitted
	logic            tq_tick;   // one pulse per quantum
	logic            sample_pt; // sample point pulse
	logic            bit_start; // new bit pulse
	logic            rx_bit;    // sampled bit
	logic [NOBJ-1:0] cfg_wr, cfg_en, tx_done, rx_done, err, flag_clr;
	logic            abort, standby, en_rx, en_tx, en_oerr;
	logic [NOBJ-1:0] in_use, status;
	modport top (output prescale, jump_w, prop_seg, rx_level, bus_idle,
		cfg_wr, cfg_en, tx_done, rx_done, err, flag_clr, abort, standby,
		en_rx, en_tx, en_oerr,
		input tq_tick, sample_pt, bit_start, rx_bit, in_use, status);
	modport tim (input prescale, jump_w, prop_seg, rx_level, bus_idle,
		output tq_tick, sample_pt, bit_start, rx_bit);
	modport obj (input cfg_wr, cfg_en, tx_done, rx_done, err, flag_clr,
		abort, standby, en_rx, en_tx, en_oerr, output in_use, status);
endinterface
`default_nettype wire

// ### src/cirq_objects.sv
`timescale 1ns/1ps
`default_nettype none
module cirq_objects
	import cirq_pkg::*;
#(
	parameter int NOBJ = 6
) (
	input wire logic mclk,
	input wire logic srst,
	cirq_core_if.obj core
);
	typedef struct packed {
		logic [NOBJ-1:0] in_use; // object busy
		logic [NOBJ-1:0] status; // object pending
	} cirq_obj_type;
	cirq_obj_type st, next_st;
	logic [NOBJ-1:0] use_set, use_clr, sit_set; // per object terms
	// one copy of the per object terms
	for (genvar i = 0; i < NOBJ; i++) begin : g_obj
		// enabling config wins over a done in the same cycle
		assign use_set[i] = core.cfg_wr[i] & core.cfg_en[i];
		assign use_clr[i] = core.tx_done[i] | core.rx_done[i] |
			(core.cfg_wr[i] & ~core.cfg_en[i]) | core.abort | core.standby;
		assign sit_set[i] = (core.rx_done[i] & core.en_rx) |
			(core.tx_done[i] & core.en_tx) | (core.err[i] & core.en_oerr);
	end
	// set beats clear on both vectors
	always_comb begin
		next_st        = st;
		next_st.in_use = use_set | (st.in_use & ~use_clr);
		next_st.status = sit_set | (st.status & ~core.flag_clr);
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign core.in_use = st.in_use;
	assign core.status = st.status;
endmodule
`default_nettype wire

// ### src/cirq_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cirq_bit_timer
	import cirq_pkg::*;
#(
	parameter int PH1_TQ = 3,
	parameter int PH2_TQ = 3
) (
	input wire logic mclk,
	input wire logic srst,
	cirq_core_if.tim core
);
	if (PH1_TQ < 1 || PH1_TQ > 8 || PH2_TQ < 2 || PH2_TQ > 8) begin : g_chk
		$error("phase lengths out of range");
	end
	typedef struct packed {
		logic [5:0]   presc;  // clock count in quantum
		cirq_seg_type seg;    // current segment
		logic [3:0]   left;   // quanta left in segment
		logic [2:0]   ext;    // pending phase 1 stretch
		logic [4:0]   pos;    // quanta since bit start
		logic         synced; // one resync per bit
		logic         prev;   // last bus level
		logic         tick, samp, start, bit_v;
	} cirq_tim_type;
	cirq_tim_type st, next_st;
	logic       tick;  // quantum boundary
	logic       edge_f; // recessive to dominant
	logic [3:0] jump;  // jump width in quanta
	logic [3:0] err;   // phase error, clipped
	assign tick   = (st.presc == core.prescale);
	assign edge_f = st.prev & ~core.rx_level;
	assign jump   = {2'b00, core.jump_w} + 4'h1;
	assign err    = (st.pos > 5'(jump)) ? jump : st.pos[3:0];
	always_comb begin
		next_st       = st;
		next_st.prev  = core.rx_level;
		next_st.presc = tick ? 6'h00 : st.presc + 6'h01;
		next_st.tick  = tick;
		next_st.samp  = 1'b0;
		next_st.start = 1'b0;
		if (tick) begin
			next_st.pos = st.pos + 5'h01;
			if (st.left <= 4'h1) begin
				unique case (st.seg)
					seg_sync: begin
						next_st.seg  = seg_prop;
						next_st.left = {1'b0, core.prop_seg} + 4'h1;
					end
					seg_prop: begin
						next_st.seg  = seg_ph1;
						next_st.left = 4'(PH1_TQ) + {1'b0, st.ext};
					end
					seg_ph1: begin
						next_st.seg   = seg_ph2;
						next_st.left  = 4'(PH2_TQ);
						next_st.samp  = 1'b1;
						next_st.bit_v = core.rx_level;
					end
					seg_ph2: begin
						next_st.seg    = seg_sync;
						next_st.left   = 4'h1;
						next_st.start  = 1'b1;
						next_st.pos    = 5'h00;
						next_st.ext    = 3'h0;
						next_st.synced = 1'b0;
					end
				endcase
			end else begin
				next_st.left = st.left - 4'h1;
			end
		end
		// edges re-align the bit; idle bus takes a hard sync
		if (edge_f && core.bus_idle) begin
			next_st.seg   = seg_sync;
			next_st.left  = 4'h1;
			next_st.pos   = 5'h00;
			next_st.presc = 6'h00;
			// a restarted bit may take its own resync again
			next_st.ext    = 3'h0;
			next_st.synced = 1'b0;
		end else if (edge_f && !st.synced && st.seg != seg_sync) begin
			next_st.synced = 1'b1;
			unique case (st.seg)
				seg_prop: next_st.ext  = err[2:0];
				seg_ph1:  next_st.left = next_st.left + err;
				seg_ph2: begin
					// early edge: cut phase 2 by at most the jump
					if (st.left <= jump) begin
						next_st.seg   = seg_sync;
						next_st.left  = 4'h1;
						next_st.pos   = 5'h00;
						next_st.start = 1'b1;
						// the cut bit is over, so the next one may resync
						next_st.ext    = 3'h0;
						next_st.synced = 1'b0;
					end else begin
						next_st.left = st.left - jump;
					end
				end
				default: next_st.ext = st.ext;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '{seg: seg_sync, left: 4'h1, prev: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end
	assign core.tq_tick   = st.tick;
	assign core.sample_pt = st.samp;
	assign core.bit_start = st.start;
	assign core.rx_bit    = st.bit_v;
endmodule
`default_nettype wire

// ### src/cirq_top.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - buffer done event sets frame buffer flag
// - buffer flag clears only after configs rewritten
// - general error flags clear on write one
// - stuff error event sets stuff flag
// - crc mismatch event sets crc flag
// - form violation event sets form flag
// - missing ack event sets ack flag
// - master enable gates all but overrun
// - overrun irq needs only its enable
// - class enables gate their interrupt classes
// - enabling an object sets its in-use bit
// - tx or rx done clears in-use
// - disable, abort, standby clear in-use
// - in-use vector is read only
// - per object enable gates object interrupt
// - status bit reads one while pending
// - quantum is prescaler plus one clocks
// - resync on the first falling bus edge of each bit outside its sync segment
// - resync moves bit by the phase error, at most jump width
// - propagation segment is field plus one
// - object status needs matching class enable
// - indicator ors all sources but overrun
// - object errors never set general flags
module cirq_top
	import cirq_pkg::*;
#(
	parameter int NOBJ   = 6,
	parameter int PH1_TQ = 3,
	parameter int PH2_TQ = 3
) (
	input  wire logic            mclk,
	input  wire logic            srst,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            can_rx,
	input  wire logic            bus_idle,
	input  wire logic            stuff_err_evt,
	input  wire logic            crc_err_evt,
	input  wire logic            form_err_evt,
	input  wire logic            ack_err_evt,
	input  wire logic            err_in_object,
	input  wire logic            frame_buffer_evt,
	input  wire logic            bus_off_evt,
	input  wire logic            timer_overrun_evt,
	input  wire logic            timer_irq_ack,
	input  wire logic [NOBJ-1:0] obj_cfg_wr,
	input  wire logic [NOBJ-1:0] obj_cfg_en,
	input  wire logic [NOBJ-1:0] obj_tx_done,
	input  wire logic [NOBJ-1:0] obj_rx_done,
	input  wire logic [NOBJ-1:0] obj_err,
	input  wire logic [NOBJ-1:0] obj_flag_clr,
	input  wire logic            abort_req,
	input  wire logic            standby_req,
	output logic                 can_irq,
	output logic                 timer_irq,
	output logic                 tq_tick,
	output logic                 sample_point,
	output logic                 bit_start,
	output logic                 rx_bit_value
);
	// the object registers hold one byte lane of six bits
	if (NOBJ != 6) begin : g_chk
		$error("object count must be six");
	end

	// everything this module remembers
	typedef struct packed {
		logic            rx_s1;     // first sync stage
		logic            rx_s2;     // second sync stage
		logic [6:0]      git;       // sticky general flags
		logic [7:0]      gie;       // general enables
		logic [NOBJ-1:0] ie;        // per object enables
		logic [5:0]      prescale;  // quantum prescaler
		logic [1:0]      jump_w;    // resync jump width
		logic [2:0]      prop_seg;  // propagation segment
		logic [NOBJ-1:0] bufsel;    // objects forming the buffer
		logic [NOBJ-1:0] rewritten; // configs seen since done
		logic [31:0]     rdata;     // captured read data
		logic            irq;       // cpu interrupt
		logic            tirq;      // timer interrupt
	} cirq_top_type;

	cirq_top_type st, next_st;

	cirq_core_if #(.NOBJ(NOBJ)) core ();

	logic       wr_acc;   // write taking effect now
	logic       rd_setup; // read setup phase
	logic [7:0] wbyte;    // low byte of write data
	logic       git_wr;   // write to flag register
	logic       gen_ok;   // general error not owned by object
	logic       fb_ready; // all buffer configs rewritten
	logic       obj_pend; // any enabled object pending
	logic       ind;      // combined indicator

	// address decode, used only for the error answer
	function automatic logic mapped(input logic [11:0] a);
		unique case (a)
			OFS_GIT, OFS_GIE, OFS_EN_LO, OFS_EN_HI, OFS_IE_LO,
			OFS_IE_HI, OFS_SIT_LO, OFS_SIT_HI, OFS_BT1, OFS_BT2,
			OFS_BUFSEL: mapped = 1'b1;
			default:    mapped = 1'b0;
		endcase
	endfunction

	// read data for one address; reserved bits come back zero
	function automatic logic [7:0] rbyte(input logic [11:0] a,
		input cirq_top_type s, input logic i,
		input logic [NOBJ-1:0] u, input logic [NOBJ-1:0] t);
		rbyte = 8'h00;
		unique case (a)
			OFS_GIT:    rbyte = {i, s.git};
			OFS_GIE:    rbyte = s.gie;
			OFS_EN_LO:  rbyte = {2'b00, u};
			OFS_IE_LO:  rbyte = {2'b00, s.ie};
			OFS_SIT_LO: rbyte = {2'b00, t};
			OFS_BT1:    rbyte = {1'b0, s.prescale, 1'b0};
			OFS_BT2:    rbyte = {1'b0, s.jump_w, 1'b0, s.prop_seg, 1'b0};
			OFS_BUFSEL: rbyte = {2'b00, s.bufsel};
			default:    rbyte = 8'h00;
		endcase
	endfunction

	// slave never stalls; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);

	// a write lands at the edge that completes the access phase
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wbyte    = pwdata[7:0];
	assign git_wr   = wr_acc & (paddr == OFS_GIT);

	// an error already owned by an object stays out of the flags
	assign gen_ok = ~err_in_object;

	// the buffer flag may only be cleared once each member object
	// has had its config rewritten since the last completion
	assign fb_ready = ((st.rewritten & st.bufsel) == st.bufsel);

	// object status is already class gated, this adds the mask
	assign obj_pend = |(core.status & st.ie);

	// polling image of every source except the timer overrun
	assign ind = (st.git[GIT_BOFF] & st.gie[GIE_BOFF]) |
		(st.git[GIT_FB] & st.gie[GIE_FB]) |
		(|st.git[GIT_STUFF:GIT_ACK] & st.gie[GIE_GERR]) |
		obj_pend;

	// next state of registers and flags
	always_comb begin
		next_st       = st;
		// bus pin passes two flops before anything reads it
		next_st.rx_s1 = can_rx;
		next_st.rx_s2 = st.rx_s1;

		// general error flags: set wins over a write-one clear
		next_st.git[GIT_STUFF] = (stuff_err_evt & gen_ok) |
			(st.git[GIT_STUFF] & ~(git_wr & wbyte[GIT_STUFF]));
		next_st.git[GIT_CRC] = (crc_err_evt & gen_ok) |
			(st.git[GIT_CRC] & ~(git_wr & wbyte[GIT_CRC]));
		next_st.git[GIT_FORM] = (form_err_evt & gen_ok) |
			(st.git[GIT_FORM] & ~(git_wr & wbyte[GIT_FORM]));
		next_st.git[GIT_ACK] = (ack_err_evt & gen_ok) |
			(st.git[GIT_ACK] & ~(git_wr & wbyte[GIT_ACK]));

		// buffer flag: a clear with configs missing is ignored
		next_st.git[GIT_FB] = frame_buffer_evt |
			(st.git[GIT_FB] & ~(git_wr & wbyte[GIT_FB] & fb_ready));

		// bus off flag, plain write-one clear
		next_st.git[GIT_BOFF] = bus_off_evt |
			(st.git[GIT_BOFF] & ~(git_wr & wbyte[GIT_BOFF]));

		// overrun also clears when its handler is entered
		next_st.git[GIT_OVR] = timer_overrun_evt | (st.git[GIT_OVR] &
			~(git_wr & wbyte[GIT_OVR]) & ~timer_irq_ack);

		// rewrite tracking restarts at each buffer completion
		if (frame_buffer_evt) begin
			next_st.rewritten = obj_cfg_wr;
		end else if (git_wr && wbyte[GIT_FB] && fb_ready) begin
			next_st.rewritten = obj_cfg_wr;
		end else begin
			next_st.rewritten = st.rewritten | obj_cfg_wr;
		end

		// software writes; reserved bits are dropped
		if (wr_acc) begin
			unique case (paddr)
				OFS_GIE:    next_st.gie = wbyte;
				OFS_IE_LO:  next_st.ie = wbyte[NOBJ-1:0];
				OFS_BT1:    next_st.prescale = wbyte[PRESC_LSB +: 6];
				OFS_BT2: begin
					next_st.jump_w   = wbyte[JUMP_LSB +: 2];
					next_st.prop_seg = wbyte[PROP_LSB +: 3];
				end
				OFS_BUFSEL: next_st.bufsel = wbyte[NOBJ-1:0];
				default:    next_st.gie = st.gie;
			endcase
		end

		// read data is caught in setup and held through access
		if (rd_setup) begin
			next_st.rdata = {24'h000000,
				rbyte(paddr, st, ind, core.in_use, core.status)};
		end

		// interrupt lines, one cycle behind their sources
		next_st.irq  = st.gie[GIE_MASTER] & ind;
		next_st.tirq = st.git[GIT_OVR] & st.gie[GIE_OVR];
	end

	// one register stage for the whole state
	always_ff @(posedge mclk) begin
		if (srst) begin
			st       <= '0;
			st.rx_s1 <= 1'b1;
			st.rx_s2 <= 1'b1;
			st.gie   <= RST_BYTE;
		end else begin
			st <= next_st;
		end
	end

	// settings and events handed to the two helpers
	assign core.prescale = st.prescale;
	assign core.jump_w   = st.jump_w;
	assign core.prop_seg = st.prop_seg;
	assign core.rx_level = st.rx_s2;
	assign core.bus_idle = bus_idle;
	assign core.cfg_wr   = obj_cfg_wr;
	assign core.cfg_en   = obj_cfg_en;
	assign core.tx_done  = obj_tx_done;
	assign core.rx_done  = obj_rx_done;
	assign core.err      = obj_err;
	assign core.flag_clr = obj_flag_clr;
	assign core.abort    = abort_req;
	assign core.standby  = standby_req;
	// class enables steer the object status (the helper sets them)
	assign core.en_rx    = st.gie[GIE_RX];
	assign core.en_tx    = st.gie[GIE_TX];
	assign core.en_oerr  = st.gie[GIE_OERR];

	// quantum prescaler and segment sequencer
	cirq_bit_timer #(
		.PH1_TQ (PH1_TQ),
		.PH2_TQ (PH2_TQ)
	) u_timer (
		.mclk (mclk),
		.srst (srst),
		.core (core.tim)
	);

	// per object in-use and status vectors
	cirq_objects #(
		.NOBJ (NOBJ)
	) u_objects (
		.mclk (mclk),
		.srst (srst),
		.core (core.obj)
	);

	// outputs straight from flops
	assign prdata       = st.rdata;
	assign can_irq      = st.irq;
	assign timer_irq    = st.tirq;
	assign tq_tick      = core.tq_tick;
	assign sample_point = core.sample_pt;
	assign bit_start    = core.bit_start;
	assign rx_bit_value = core.rx_bit;
endmodule
`default_nettype wire

// ### verification/cirq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cirq_monitor
	import cirq_pkg::*;
#(
	parameter int PH1_TQ = 3,
	parameter int PH2_TQ = 3
) (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        can_rx,
	input wire logic        bus_idle,
	input wire logic        stuff_err_evt,
	input wire logic        err_in_object,
	input wire logic        bus_off_evt,
	input wire logic        timer_overrun_evt,
	input wire logic        can_irq,
	input wire logic        timer_irq,
	input wire logic        tq_tick,
	input wire logic        bit_start
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	logic        wr;    // write lands this edge
	logic [7:0]  gie;   // enable shadow
	logic [7:0]  bt1;   // prescaler shadow
	logic [7:0]  bt2;   // jump and propagation shadow
	logic [1:0]  nbs;   // bit starts since timing write
	logic        rx_q;  // last bus level
	logic [11:0] len;   // clocks since bit start
	logic [11:0] gap;   // clocks since quantum tick
	logic [11:0] quiet; // clocks without edge or idle
	int          base;  // nominal bit in clocks
	int          tol;   // jump plus a part quantum of slack
	assign wr   = psel && penable && pwrite;
	assign base = (PH1_TQ + PH2_TQ + 2 + int'(bt2[3:1]))
		* (int'(bt1[6:1]) + 1);
	assign tol  = (int'(bt2[6:5]) + 2) * (int'(bt1[6:1]) + 1) - 1;
	// shadows follow apb writes; counters time the bit timer
	always_ff @(posedge mclk) begin
		if (srst) begin
			gie   <= 8'h00;
			bt1   <= 8'h00;
			bt2   <= 8'h00;
			nbs   <= 2'h0;
			rx_q  <= 1'b1;
			len   <= 12'h000;
			gap   <= 12'h000;
			quiet <= 12'h000;
		end else begin
			if (wr && paddr == OFS_GIE)
				gie <= pwdata[7:0];
			if (wr && paddr == OFS_BT1)
				bt1 <= pwdata[7:0];
			if (wr && paddr == OFS_BT2)
				bt2 <= pwdata[7:0];
			// old settings may still shape the bit in flight
			if (wr && (paddr == OFS_BT1 || paddr == OFS_BT2))
				nbs <= 2'h0;
			else if (bit_start && nbs != 2'h3)
				nbs <= nbs + 2'h1;
			rx_q <= can_rx;
			len  <= bit_start ? 12'h001 : len + 12'h001;
			gap  <= tq_tick ? 12'h001 : gap + 12'h001;
			// saturating, so long idle never wraps
			if (can_rx != rx_q || bus_idle)
				quiet <= 12'h000;
			else
				quiet <= quiet + {11'h000, ~&quiet};
		end
	end
	tq_gap_a: assert property (
		tq_tick && nbs == 2'h3 && quiet > gap + 4 |-> gap == bt1[6:1] + 1)
		else $error("quantum spacing wrong");
	bit_len_a: assert property (
		bit_start && nbs == 2'h3 && quiet > len + 4 |-> len == base)
		else $error("bit length wrong without edges");
	resync_bound_a: assert property (
		bit_start && nbs == 2'h3 |-> len >= base - tol && len <= base + tol)
		else $error("resync moved bit too far");
	master_gate_a: assert property (
		!gie[GIE_MASTER] |=> !can_irq)
		else $error("irq without master enable");
	ovr_gate_a: assert property (
		!gie[GIE_OVR] |=> !timer_irq)
		else $error("overrun irq without its enable");
	ovr_raise_a: assert property (
		timer_overrun_evt && gie[GIE_OVR] |-> ##2 timer_irq)
		else $error("overrun irq missing");
	stuff_raise_a: assert property (
		stuff_err_evt && !err_in_object && gie[GIE_MASTER] && gie[GIE_GERR]
		|-> ##2 can_irq)
		else $error("stuff error irq missing");
	boff_raise_a: assert property (
		bus_off_evt && gie[GIE_MASTER] && gie[GIE_BOFF] |-> ##2 can_irq)
		else $error("bus off irq missing");
endmodule
bind cirq_top cirq_monitor #(.PH1_TQ(PH1_TQ), .PH2_TQ(PH2_TQ))
	u_cirq_monitor (.mclk(mclk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.can_rx(can_rx), .bus_idle(bus_idle), .stuff_err_evt(stuff_err_evt),
	.err_in_object(err_in_object), .bus_off_evt(bus_off_evt),
	.timer_overrun_evt(timer_overrun_evt), .can_irq(can_irq),
	.timer_irq(timer_irq), .tq_tick(tq_tick), .bit_start(bit_start));
`default_nettype wire

// ### verification/cirq_can_node.sv
`timescale 1ns/1ps
`default_nettype none
module cirq_can_node (
	input  wire logic mclk,
	output var  logic can_rx
);
	// recessive whenever no frame is on the wire
	initial can_rx = 1'b1;
	// bit length differs from ours to force resyncs
	task automatic send(input logic [15:0] bits, input int n, input int blen);
		@(posedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			can_rx <= bits[i];
			repeat (blen) @(posedge mclk);
		end
		can_rx <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### verification/cirq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	checks_done++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("Error %0t: got %h want %h", $time, a, b); \
	end \
end
module cirq_top_tb import cirq_pkg::*;;
	localparam int PH = 3;        // phase lengths in quanta
	logic        mclk = 1'b0;     // 20 mhz clock
	logic        srst = 1'b1;     // held ten cycles
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        bus_idle = 1'b0; // no hard syncs wanted
	logic [10:0] ev = 11'h000;    // event, ack, abort, standby
	logic [5:0]  ocw = 6'h00, oce = 6'h00, otx = 6'h00;
	logic [5:0]  orx = 6'h00, oer = 6'h00, ocl = 6'h00;
	logic [31:0] prdata;
	logic        pready, pslverr, can_rx, can_irq, timer_irq;
	logic        tq_tick, sample_point, bit_start, rx_bit_value;
	int          n_mismatch = 0;
	int          checks_done = 0;
	always #25 mclk = ~mclk;
	cirq_top #(.PH1_TQ(PH), .PH2_TQ(PH)) u_cirq_top (
		.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .can_rx(can_rx),
		.bus_idle(bus_idle), .stuff_err_evt(ev[3]), .crc_err_evt(ev[2]),
		.form_err_evt(ev[1]), .ack_err_evt(ev[0]), .err_in_object(ev[4]),
		.frame_buffer_evt(ev[5]), .bus_off_evt(ev[6]),
		.timer_overrun_evt(ev[7]), .timer_irq_ack(ev[8]),
		.obj_cfg_wr(ocw), .obj_cfg_en(oce), .obj_tx_done(otx),
		.obj_rx_done(orx), .obj_err(oer), .obj_flag_clr(ocl),
		.abort_req(ev[9]), .standby_req(ev[10]), .can_irq(can_irq),
		.timer_irq(timer_irq), .tq_tick(tq_tick),
		.sample_point(sample_point), .bit_start(bit_start),
		.rx_bit_value(rx_bit_value));
	cirq_can_node u_cirq_can_node (.mclk(mclk), .can_rx(can_rx));
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			final_report();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 8'h00, q, e);
		`CHK(q, {24'h000000, x})
	endtask
	// one-cycle pulse, then wait until the irq register has moved
	task automatic drive(input logic [10:0] m, input logic [35:0] o);
		@(posedge mclk);
		ev <= m;
		{ocw, oce, otx, orx, oer, ocl} <= o;
		@(posedge mclk);
		ev <= 11'h000;
		{ocw, oce, otx, orx, oer, ocl} <= 36'h0;
		@(posedge mclk);
		@(negedge mclk);
	endtask
	// clocks between two bit starts, bounded
	// also counts sample points inside the measured bit
	task automatic bit_gap(output int c, output int s);
		int n;
		n = 0;
		c = 0;
		s = 0;
		for (int k = 0; k < 2; k++) begin
			c = 0;
			s = 0;
			do begin
				@(negedge mclk);
				c++;
				n++;
				s += int'(sample_point === 1'b1);
			end while (bit_start !== 1'b1 && n < 400);
		end
		if (n >= 400) begin
			n_mismatch++;
			final_report();
		end
	endtask
	initial begin
		int          c;
		int          s;
		logic [31:0] q;
		logic        e;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd(OFS_GIT + 12'(4 * i), 8'h00);
		// unmapped word: error, zero data
		apb(1'b0, 12'h100, 8'h00, q, e);
		`CHK({e, q}, 33'h100000000)
		wr(OFS_GIE, 8'h82);
		rd(OFS_GIE, 8'h82);
		// each general error: set, survive zero, clear on one
		for (int i = 0; i < 4; i++) begin
			drive(11'(1 << i), 36'h0);
			`CHK(can_irq, 1'b1)
			wr(OFS_GIT, 8'h00);
			rd(OFS_GIT, 8'h80 | 8'(1 << i));
			wr(OFS_GIT, 8'(1 << i));
			rd(OFS_GIT, 8'h00);
		end
		drive(11'h018, 36'h0);
		rd(OFS_GIT, 8'h00);
		// overrun bypasses master and indicator
		wr(OFS_GIE, 8'h01);
		drive(11'h080, 36'h0);
		`CHK({timer_irq, can_irq}, 2'b10)
		rd(OFS_GIT, 8'h20);
		drive(11'h100, 36'h0);
		`CHK(timer_irq, 1'b0)
		wr(OFS_GIE, 8'hc0);
		drive(11'h040, 36'h0);
		`CHK(can_irq, 1'b1)
		wr(OFS_GIE, 8'h40);
		repeat (2) @(negedge mclk);
		`CHK(can_irq, 1'b0)
		wr(OFS_GIE, 8'h80);
		repeat (2) @(negedge mclk);
		`CHK(can_irq, 1'b0)
		wr(OFS_GIT, 8'h40);
		// buffer flag needs both members rewritten first
		wr(OFS_BUFSEL, 8'h03);
		drive(11'h020, 36'h0);
		rd(OFS_GIT, 8'h10);
		for (int i = 0; i < 3; i++) begin
			if (i > 0)
				drive(11'h0, {6'(i), 30'h0});
			wr(OFS_GIT, 8'h10);
			rd(OFS_GIT, i == 2 ? 8'h00 : 8'h10);
		end
		drive(11'h0, {6'h05, 6'h05, 24'h0});
		rd(OFS_EN_LO, 8'h05);
		drive(11'h0, {12'h0, 6'h01, 18'h0});
		wr(OFS_EN_LO, 8'hff);
		rd(OFS_EN_LO, 8'h04);
		drive(11'h0, {18'h0, 6'h04, 12'h0});
		rd(OFS_EN_LO, 8'h00);
		// disable config, then abort, then standby
		for (int i = 0; i < 3; i++) begin
			drive(11'h0, {6'h3f, 6'h3f, 24'h0});
			drive(i == 0 ? 11'h0 : 11'h100 << i, i == 0 ? {6'h01, 30'h0} : 36'h0);
			rd(OFS_EN_LO, i == 0 ? 8'h3e : 8'h00);
		end
		rd(OFS_EN_HI, 8'h00);
		wr(OFS_IE_LO, 8'h3f);
		rd(OFS_IE_LO, 8'h3f);
		wr(OFS_GIE, 8'ha8);
		drive(11'h0, {18'h0, 6'h02, 12'h0});
		drive(11'h0, {12'h0, 6'h04, 18'h0});
		drive(11'h0, {24'h0, 6'h08, 6'h0});
		rd(OFS_SIT_LO, 8'h0a);
		`CHK(can_irq, 1'b1)
		wr(OFS_IE_LO, 8'h00);
		repeat (2) @(negedge mclk);
		`CHK(can_irq, 1'b0)
		drive(11'h0, {30'h0, 6'h0a});
		rd(OFS_SIT_LO, 8'h00);
		wr(OFS_BT1, 8'h02);
		wr(OFS_BT2, 8'h24);
		rd(OFS_BT1, 8'h02);
		rd(OFS_BT2, 8'h24);
		bit_gap(c, s);
		`CHK(c, (1 + 3 + PH + PH) * 2)
		`CHK(s, 1)
		`CHK(rx_bit_value, 1'b1)
		// a slow then a fast node drags our bit edges
		u_cirq_can_node.send(16'ha5c3, 16, 21);
		u_cirq_can_node.send(16'h5a3c, 16, 19);
		repeat (100) @(posedge mclk);
		final_report();
	end
endmodule
`default_nettype wire
